// >>> logic/mscp_pkg.sv
// Constants and types for the monitor serial command port
package mscp_pkg;
  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  localparam int         DIV_W      = 11;
  localparam logic [10:0] DIV_FAST  = 11'h200;
  localparam logic [10:0] DIV_SLOW  = 11'h400;
  localparam logic [3:0] TX_BITS    = 4'hC;
  localparam logic [1:0] TX_GAP     = 2'h3;
  localparam logic [9:0] TX_BRK     = 10'h000;
  localparam logic [3:0] HOLD_BITS  = 4'hB;
  localparam logic [3:0] RX_STOP    = 4'h9;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_READ    = 8'h4A;
  localparam logic [7:0] OP_INDEXED_WRITE_CMD  = 8'h19;
  localparam logic [7:0] OP_STACK_POINTER_READ_CMD  = 8'h0C;
  localparam logic [7:0] OP_RUN     = 8'h28;
  // ----------------------------------------
  // Memory map
  // ----------------------------------------
  localparam logic [15:0] SEC_BASE    = 16'hFFF6;
  localparam logic [2:0]  SEC_LAST    = 3'h7;
  localparam logic [15:0] STATUS_ADDR = 16'h0060;
  localparam logic [7:0]  STATUS_OK   = 8'h40;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;
  localparam logic [15:0] PC_HI_OFS   = 16'h0005;
  localparam logic [15:0] PC_LO_OFS   = 16'h0006;
  localparam logic [7:0]  BLANK       = 8'hFF;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_DATA = 2'h1,
    RX_REL  = 2'h3
  } mscp_rx_t;
  typedef enum logic [3:0] {
    S_SEC_WAIT = 4'h0,
    S_ECHO     = 4'h1,
    S_SEC_CMP  = 4'h3,
    S_IDLE     = 4'h2,
    S_HOLD     = 4'h6,
    S_EXEC     = 4'h7,
    S_MEMRD    = 4'h5,
    S_RESP     = 4'h4,
    S_STATUS   = 4'hC,
    S_READY    = 4'hD
  } mscp_state_t;
endpackage

// >>> logic/mscp_rx.sv
// Serial receiver with break detection
`timescale 1ns/1ps
module mscp_rx #(
  parameter int DIV_W = mscp_pkg::DIV_W
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             en,
  input  wire logic [DIV_W-1:0] bit_div,
  input  wire logic             line,
  output logic                  byte_valid,
  output logic [7:0]            rx_byte,
  output logic                  rx_break
);
  mscp_pkg::mscp_rx_t st;
  logic [DIV_W-1:0]   tmr;
  logic [3:0]         cnt;
  logic [8:0]         sh;

  // ----------------------------------------
  // Frame sampling at mid bit
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st         <= mscp_pkg::RX_IDLE;
      tmr        <= '0;
      cnt        <= '0;
      sh         <= '0;
      byte_valid <= 1'b0;
      rx_break   <= 1'b0;
      rx_byte    <= '0;
    end else if (ce) begin
      byte_valid <= 1'b0;
      rx_break   <= 1'b0;
      unique case (st)
        mscp_pkg::RX_IDLE: begin
          if (en && !line) begin
            tmr <= bit_div >> 1;
            cnt <= '0;
            st  <= mscp_pkg::RX_DATA;
          end
        end
        mscp_pkg::RX_DATA: begin
          if (tmr != '0) begin
            tmr <= tmr - 1'b1;
          end else begin
            tmr <= bit_div - 1'b1;
            cnt <= cnt + 1'b1;
            sh  <= {line, sh[8:1]};
            if (cnt == '0 && line) begin
              st <= mscp_pkg::RX_IDLE;
            end else if (cnt == mscp_pkg::RX_STOP) begin
              if (line) begin
                byte_valid <= 1'b1;
                rx_byte    <= sh[8:1];
                st         <= mscp_pkg::RX_IDLE;
              end else begin
                rx_break <= (sh[8:1] == 8'h00);
                st       <= mscp_pkg::RX_REL;
              end
            end
          end
        end
        mscp_pkg::RX_REL: begin
          // Rearm only on a high line, else a long break retriggers
          if (line) begin
            st <= mscp_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// >>> logic/mscp_tx.sv
// Serial transmitter, two idle bits ahead of every frame
`timescale 1ns/1ps
module mscp_tx #(
  parameter int DIV_W = mscp_pkg::DIV_W
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [DIV_W-1:0] bit_div,
  input  wire logic             go,
  input  wire logic             brk,
  input  wire logic [7:0]       data,
  output logic                  busy,
  output logic                  done,
  output logic                  line_out,
  output logic                  line_oe
);
  logic [11:0]      sh;
  logic [3:0]       left;
  logic [DIV_W-1:0] tmr;

  assign busy     = line_oe;
  assign line_out = sh[0];

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sh      <= '1;
      left    <= '0;
      tmr     <= '0;
      line_oe <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!line_oe) begin
        if (go) begin
          sh      <= brk ? {mscp_pkg::TX_BRK, mscp_pkg::TX_GAP}
                         : {1'b1, data, 1'b0, mscp_pkg::TX_GAP};
          left    <= mscp_pkg::TX_BITS;
          tmr     <= bit_div - 1'b1;
          line_oe <= 1'b1;
        end
      end else if (tmr != '0) begin
        tmr <= tmr - 1'b1;
      end else if (left == 4'h1) begin
        line_oe <= 1'b0;
        done    <= 1'b1;
        sh      <= '1;
      end else begin
        sh   <= {1'b1, sh[11:1]};
        left <= left - 1'b1;
        tmr  <= bit_div - 1'b1;
      end
    end
  end
endmodule

// >>> logic/mscp_core.sv
// Monitor command engine on a single-wire serial pin
// Contract
// - Break is start plus nine low bits
// - Break answered by two high bits, then break
// - Test-voltage entry: divider 1024 if select high, else 512
// - Supply-voltage entry: divider fixed at 1024
// - Every received byte is echoed; bytes received during the post-command wait are dropped
// - Eleven bit wait after command; break aborts
// - Two bit gap before echo and data
// - Read data follows the last echo
// - Read 0x4A, address high first, returns byte
// - Indexed write 0x19 stores at last address plus one
// - Indexed access steps over all 64K
// - Stack read 0x0C returns SP plus one, high first
// - Run 0x28 pops index high and returns
// - Entry takes software interrupt, pushes index high
// - Stacked PC at SP plus five and six
// - After power-on, compare eight bytes from 0xFFF6
// - Security pass survives non power-on resets
// - Failed check: invalid flash reads, fetch blocked
// - Ready break only after all eight bytes; a non power-on reset sends it at once
// - Pass sets bit 6 of RAM 0x60
// - Erased security bytes read 0xFF
// - NRZ, same rate both directions
`timescale 1ns/1ps
module mscp_core #(
  parameter logic [7:0]  OP_WRITE   = 8'h49,
  parameter logic [7:0]  OP_INDEXED_READ_CMD   = 8'h1A,
  parameter logic [15:0] FLASH_BASE = 16'h0800,
  parameter logic [7:0]  INVALID    = 8'hAD
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        por_reset,
  input  wire logic        entry_voltage_pin,
  input  wire logic        divider_select_pin,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_oe,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [15:0] stack_pointer,
  output logic             swi_entry,
  output logic             run_pulse,
  output logic [15:0]      pc_hi_addr,
  output logic [15:0]      pc_lo_addr,
  output logic             security_ok,
  output logic             security_blank,
  output logic             flash_fetch_block,
  output logic             cmd_ready
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  mscp_pkg::mscp_state_t  state;
  logic [mscp_pkg::DIV_W-1:0] bit_div;
  logic                   rx_valid;
  logic                   rx_break;
  logic [7:0]             rx_byte;
  logic                   rx_en;
  logic                   tx_go;
  logic                   tx_brk;
  logic [7:0]             tx_byte;
  logic                   tx_busy;
  logic                   tx_done;
  logic                   tx_idle;
  logic                   echo_brk;
  logic                   sec_active;
  logic [2:0]             sec_idx;
  logic                   sec_match;
  logic                   cmp_issued;
  logic                   mem_re_d;
  logic                   entry_done;
  logic [7:0]             cur_byte;
  logic [7:0]             opcode;
  logic [23:0]            args;
  logic [1:0]             arg_cnt;
  logic [1:0]             arg_need;
  logic [2:0]             cur_ops;
  logic [15:0]            last_addr;
  logic [15:0]            resp;
  logic [1:0]             resp_n;
  logic [mscp_pkg::DIV_W-1:0] tmr;
  logic [3:0]             hold_cnt;

  // Operand count; bit 2 flags a known opcode
  function automatic logic [2:0] cmd_operands(input logic [7:0] op);
    if (op == mscp_pkg::OP_READ) begin
      cmd_operands = 3'h6;
    end else if (op == OP_WRITE) begin
      cmd_operands = 3'h7;
    end else if (op == mscp_pkg::OP_INDEXED_WRITE_CMD) begin
      cmd_operands = 3'h5;
    end else if (op == OP_INDEXED_READ_CMD || op == mscp_pkg::OP_STACK_POINTER_READ_CMD || op == mscp_pkg::OP_RUN) begin
      cmd_operands = 3'h4;
    end else begin
      cmd_operands = 3'h0;
    end
  endfunction

  // ----------------------------------------
  // Serial ends
  // ----------------------------------------
  assign tx_idle = !tx_busy && !tx_go;
  assign cur_ops = cmd_operands(cur_byte);
  // Own echo must not be heard back on the shared pin
  assign rx_en = tx_idle && (state == mscp_pkg::S_SEC_WAIT || state == mscp_pkg::S_IDLE ||
                             state == mscp_pkg::S_HOLD);
  assign cmd_ready         = !sec_active;
  assign flash_fetch_block = !security_ok;

  mscp_rx u_rx (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .en         (rx_en),
    .bit_div    (bit_div),
    .line       (serial_in),
    .byte_valid (rx_valid),
    .rx_byte    (rx_byte),
    .rx_break   (rx_break)
  );

  // Same divider both ways keeps the rates equal
  mscp_tx u_tx (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .bit_div  (bit_div),
    .go       (tx_go),
    .brk      (tx_brk),
    .data     (tx_byte),
    .busy     (tx_busy),
    .done     (tx_done),
    .line_out (serial_out),
    .line_oe  (serial_oe)
  );

  // ----------------------------------------
  // Divider strap, caught while in reset
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_div <= (entry_voltage_pin && !divider_select_pin) ? mscp_pkg::DIV_FAST
                                                            : mscp_pkg::DIV_SLOW;
    end
  end

  // ----------------------------------------
  // Security flag, cleared by power-on only
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      if (por_reset) begin
        security_ok <= 1'b0;
      end
    end else if (ce && state == mscp_pkg::S_STATUS && sec_match) begin
      security_ok <= 1'b1;
    end
  end

  // ----------------------------------------
  // Entry and stack frame
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      entry_done <= 1'b0;
      swi_entry  <= 1'b0;
      pc_hi_addr <= '0;
      pc_lo_addr <= '0;
    end else if (ce) begin
      entry_done <= 1'b1;
      swi_entry  <= !entry_done;
      pc_hi_addr <= stack_pointer + mscp_pkg::PC_HI_OFS;
      pc_lo_addr <= stack_pointer + mscp_pkg::PC_LO_OFS;
    end
  end

  // ----------------------------------------
  // Read strobe delay marks valid read data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_re_d <= 1'b0;
    end else if (ce) begin
      mem_re_d <= mem_re;
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state          <= por_reset ? mscp_pkg::S_SEC_WAIT : mscp_pkg::S_READY;
      sec_active     <= por_reset;
      sec_idx        <= '0;
      sec_match      <= 1'b1;
      security_blank <= 1'b1;
      cmp_issued     <= 1'b0;
      echo_brk       <= 1'b0;
      tx_go          <= 1'b0;
      tx_brk         <= 1'b0;
      tx_byte        <= '0;
      cur_byte       <= '0;
      opcode         <= '0;
      args           <= '0;
      arg_cnt        <= '0;
      arg_need       <= '0;
      last_addr      <= '0;
      resp           <= '0;
      resp_n         <= '0;
      tmr            <= '0;
      hold_cnt       <= '0;
      mem_addr       <= '0;
      mem_wdata      <= '0;
      mem_we         <= 1'b0;
      mem_re         <= 1'b0;
      run_pulse      <= 1'b0;
    end else if (ce) begin
      tx_go     <= 1'b0;
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
      run_pulse <= 1'b0;
      unique case (state)
        mscp_pkg::S_SEC_WAIT, mscp_pkg::S_IDLE, mscp_pkg::S_HOLD: begin
          if (rx_break) begin
            tx_go    <= 1'b1;
            tx_brk   <= 1'b1;
            echo_brk <= 1'b1;
            state    <= mscp_pkg::S_ECHO;
          end else if (rx_valid && state != mscp_pkg::S_HOLD) begin
            cur_byte <= rx_byte;
            tx_byte  <= rx_byte;
            tx_brk   <= 1'b0;
            tx_go    <= 1'b1;
            echo_brk <= 1'b0;
            state    <= mscp_pkg::S_ECHO;
          end else if (state == mscp_pkg::S_HOLD) begin
            if (tmr != '0) begin
              tmr <= tmr - 1'b1;
            end else if (hold_cnt == 4'h1) begin
              state <= mscp_pkg::S_EXEC;
            end else begin
              hold_cnt <= hold_cnt - 1'b1;
              tmr      <= bit_div - 1'b1;
            end
          end
        end
        mscp_pkg::S_ECHO: begin
          if (tx_done) begin
            if (echo_brk) begin
              arg_cnt <= '0;
              state   <= sec_active ? mscp_pkg::S_SEC_WAIT : mscp_pkg::S_IDLE;
            end else if (sec_active) begin
              state <= mscp_pkg::S_SEC_CMP;
            end else if (arg_cnt == '0) begin
              opcode   <= cur_byte;
              arg_need <= cur_ops[1:0];
              if (!cur_ops[2]) begin
                state <= mscp_pkg::S_IDLE;
              end else if (cur_ops[1:0] == '0) begin
                tmr      <= bit_div - 1'b1;
                hold_cnt <= mscp_pkg::HOLD_BITS;
                state    <= mscp_pkg::S_HOLD;
              end else begin
                arg_cnt <= 2'h1;
                state   <= mscp_pkg::S_IDLE;
              end
            end else begin
              args <= {args[15:0], cur_byte};
              if (arg_cnt == arg_need) begin
                arg_cnt  <= '0;
                tmr      <= bit_div - 1'b1;
                hold_cnt <= mscp_pkg::HOLD_BITS;
                state    <= mscp_pkg::S_HOLD;
              end else begin
                arg_cnt <= arg_cnt + 1'b1;
                state   <= mscp_pkg::S_IDLE;
              end
            end
          end
        end
        mscp_pkg::S_SEC_CMP: begin
          if (!cmp_issued) begin
            mem_addr   <= mscp_pkg::SEC_BASE + {13'h0000, sec_idx};
            mem_re     <= 1'b1;
            cmp_issued <= 1'b1;
          end else if (mem_re_d) begin
            cmp_issued     <= 1'b0;
            sec_match      <= sec_match && (mem_rdata == cur_byte);
            security_blank <= security_blank && (mem_rdata == mscp_pkg::BLANK);
            sec_idx        <= sec_idx + 1'b1;
            state          <= (sec_idx == mscp_pkg::SEC_LAST) ? mscp_pkg::S_STATUS
                                                              : mscp_pkg::S_SEC_WAIT;
          end
        end
        mscp_pkg::S_STATUS: begin
          if (sec_match) begin
            mem_addr  <= mscp_pkg::STATUS_ADDR;
            mem_wdata <= mscp_pkg::STATUS_OK;
            mem_we    <= 1'b1;
          end
          state <= mscp_pkg::S_READY;
        end
        mscp_pkg::S_READY: begin
          if (tx_idle) begin
            tx_go      <= 1'b1;
            tx_brk     <= 1'b1;
            echo_brk   <= 1'b1;
            sec_active <= 1'b0;
            state      <= mscp_pkg::S_ECHO;
          end
        end
        mscp_pkg::S_EXEC: begin
          state <= mscp_pkg::S_IDLE;
          if (opcode == mscp_pkg::OP_READ) begin
            mem_addr  <= args[15:0];
            last_addr <= args[15:0];
            mem_re    <= 1'b1;
            state     <= mscp_pkg::S_MEMRD;
          end else if (opcode == OP_WRITE) begin
            mem_addr  <= args[23:8];
            last_addr <= args[23:8];
            mem_wdata <= args[7:0];
            mem_we    <= 1'b1;
          end else if (opcode == mscp_pkg::OP_INDEXED_WRITE_CMD) begin
            mem_addr  <= last_addr + mscp_pkg::ADDR_STEP;
            last_addr <= last_addr + mscp_pkg::ADDR_STEP;
            mem_wdata <= args[7:0];
            mem_we    <= 1'b1;
          end else if (opcode == OP_INDEXED_READ_CMD) begin
            mem_addr  <= last_addr + mscp_pkg::ADDR_STEP;
            last_addr <= last_addr + mscp_pkg::ADDR_STEP;
            mem_re    <= 1'b1;
            state     <= mscp_pkg::S_MEMRD;
          end else if (opcode == mscp_pkg::OP_STACK_POINTER_READ_CMD) begin
            resp   <= stack_pointer + mscp_pkg::ADDR_STEP;
            resp_n <= 2'h2;
            state  <= mscp_pkg::S_RESP;
          end else begin
            run_pulse <= 1'b1;
          end
        end
        mscp_pkg::S_MEMRD: begin
          if (mem_re_d) begin
            // Locked flash hides its contents behind a fixed byte
            resp[15:8] <= (!security_ok && mem_addr >= FLASH_BASE) ? INVALID : mem_rdata;
            resp_n     <= 2'h1;
            state      <= mscp_pkg::S_RESP;
          end
        end
        mscp_pkg::S_RESP: begin
          if (resp_n == '0) begin
            if (tx_idle) begin
              state <= mscp_pkg::S_IDLE;
            end
          end else if (tx_idle) begin
            tx_byte <= resp[15:8];
            tx_brk  <= 1'b0;
            tx_go   <= 1'b1;
            resp    <= {resp[7:0], 8'h00};
            resp_n  <= resp_n - 1'b1;
          end
        end
        default: begin
          state <= mscp_pkg::S_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> dv/mscp_core_properties.sv
// Port checker for the monitor command engine
`timescale 1ns/1ps
module mscp_core_properties (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        entry_voltage_pin,
  input wire logic        divider_select_pin,
  input wire logic        serial_out,
  input wire logic        serial_oe,
  input wire logic        mem_re,
  input wire logic [15:0] stack_pointer,
  input wire logic        swi_entry,
  input wire logic [15:0] pc_hi_addr,
  input wire logic [15:0] pc_lo_addr,
  input wire logic        security_ok,
  input wire logic        flash_fetch_block
);
  logic [10:0] div;
  logic [13:0] oe_cnt;
  // ----
  // Helpers
  // ----
  // Pins are latched only while reset is held, as at monitor entry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div <= (entry_voltage_pin && !divider_select_pin) ? mscp_pkg::DIV_FAST : mscp_pkg::DIV_SLOW;
    end
  end
  always_ff @(posedge clk) begin
    oe_cnt <= (nrst && serial_oe) ? oe_cnt + 14'h0001 : 14'h0000;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_release;
    $rose(nrst);
  endsequence
  sequence s_gap;
    serial_oe && (oe_cnt < {2'h0, div, 1'b0});
  endsequence
  sequence s_start;
    serial_oe && (oe_cnt == {2'h0, div, 1'b0});
  endsequence
  // ----
  // Checks
  // ----
  a_swi_after_release: assert property (s_release |=> swi_entry)
    else $error("swi_entry missing after reset release");
  a_pc_high_addr: assert property ($past(nrst) |-> pc_hi_addr == $past(stack_pointer) + mscp_pkg::PC_HI_OFS)
    else $error("pc_hi_addr not stack pointer plus five");
  a_pc_low_addr: assert property ($past(nrst) |-> pc_lo_addr == $past(stack_pointer) + mscp_pkg::PC_LO_OFS)
    else $error("pc_lo_addr not stack pointer plus six");
  a_gap_held_high: assert property (s_gap |-> serial_out)
    else $error("line low inside the two bit gap");
  a_start_on_time: assert property (s_start |-> !serial_out)
    else $error("first low bit not two bit periods after drive");
  a_frame_length: assert property ($past(nrst) && $fell(serial_oe) |-> oe_cnt == 14'(12 * div))
    else $error("drive time is not twelve bit periods");
  a_read_after_echo: assert property (mem_re |-> !serial_oe)
    else $error("memory read while transmitting");
  a_fetch_block: assert property (flash_fetch_block == !security_ok)
    else $error("fetch block does not follow security state");
endmodule

bind mscp_core mscp_core_properties u_props (
  .clk(clk), .nrst(nrst), .entry_voltage_pin(entry_voltage_pin),
  .divider_select_pin(divider_select_pin), .serial_out(serial_out),
  .serial_oe(serial_oe), .mem_re(mem_re), .stack_pointer(stack_pointer),
  .swi_entry(swi_entry), .pc_hi_addr(pc_hi_addr), .pc_lo_addr(pc_lo_addr),
  .security_ok(security_ok), .flash_fetch_block(flash_fetch_block)
);

// >>> dv/mscp_host.sv
// Host programmer model on the shared serial wire
`timescale 1ns/1ps
module mscp_host #(
  parameter int BIT = 512
) (
  input  wire logic clk,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      line
);
  logic host_oe = 1'b0;
  logic host_out = 1'b1;
  // Pull-up: a released wire reads high, never a stale value
  assign line = (dev_oe ? dev_out : 1'b1) & (host_oe ? host_out : 1'b1);
  // ----
  // Byte transfers
  // ----
  // Start low, data LSB first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_oe <= 1'b1;
      host_out <= f[i];
      repeat (BIT) @(posedge clk);
    end
    host_oe <= 1'b0;
  endtask
  task automatic recv(output logic [9:0] f, output bit ok);
    int n;
    n = 0;
    while (line !== 1'b0 && n < 40 * BIT) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 40 * BIT);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = line;
      repeat (BIT) @(posedge clk);
    end
    repeat (BIT) @(posedge clk);
  endtask
endmodule

// >>> dv/mscp_core_test.sv
// Self-checking bench for the monitor command engine
`timescale 1ns/1ps
module mscp_core_test;
  localparam int BIT = 512;
  logic        clk, line, serial_out, serial_oe, mem_we, mem_re;
  logic        swi_entry, run_pulse, security_ok, flash_fetch_block, cmd_ready;
  logic        nrst = 1'b0;
  logic        por_reset = 1'b1;
  logic        entry_pin = 1'b1;
  logic        div_sel = 1'b0;
  logic [15:0] mem_addr, rd_addr, wr_addr;
  logic [7:0]  mem_wdata, wr_data;
  logic [7:0]  mem_rdata = 8'h00;
  int          n_swi = 0;
  int          n_mismatch = 0;
  int          compares = 0;

  mscp_core u_dut (
    .clk(clk), .nrst(nrst), .ce(1'b1), .por_reset(por_reset),
    .entry_voltage_pin(entry_pin), .divider_select_pin(div_sel),
    .serial_in(line), .serial_out(serial_out), .serial_oe(serial_oe),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .stack_pointer(16'h00F0),
    .swi_entry(swi_entry), .run_pulse(run_pulse), .pc_hi_addr(),
    .pc_lo_addr(), .security_ok(security_ok), .security_blank(),
    .flash_fetch_block(flash_fetch_block), .cmd_ready(cmd_ready)
  );
  mscp_host #(.BIT(BIT)) u_host (.clk(clk), .dev_out(serial_out), .dev_oe(serial_oe), .line(line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // Memory, answers the cycle after the strobe
  // ----
  always @(posedge clk) begin
    if (mem_re) begin
      mem_rdata <= mem_addr[7:0] ^ 8'h5A;
      rd_addr <= mem_addr;
    end
    if (mem_we) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
    if (swi_entry) begin
      n_swi <= n_swi + 1;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_reset(input logic por);
    nrst <= 1'b0;
    por_reset <= por;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // A frame that never starts ends the run
  task automatic expect_frame(input string what, input logic [9:0] exp);
    logic [9:0] f;
    bit         ok;
    u_host.recv(f, ok);
    chk(what, {6'h0, exp}, {6'h0, f});
    if (!ok) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic xfer(input logic [7:0] b);
    u_host.send(b);
    expect_frame("echo", {1'b1, b, 1'b0});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_por_hold();
    int hi;
    hi = 0;
    do_reset(1'b1);
    for (int i = 0; i < 3 * BIT; i++) begin
      @(posedge clk);
      hi += (line === 1'b1);
    end
    chk("quiet", 16'(3 * BIT), 16'(hi));
    chk("ready", 16'h0, {15'h0, cmd_ready});
    chk("swi", 16'h1, 16'(n_swi));
    chk("fetch", 16'h1, {15'h0, flash_fetch_block});
  endtask
  task automatic t_warm();
    do_reset(1'b0);
    expect_frame("break", 10'h000);
    chk("ready", 16'h1, {15'h0, cmd_ready});
    chk("kept", 16'h0, {15'h0, security_ok});
  endtask
  task automatic t_read();
    xfer(mscp_pkg::OP_READ);
    xfer(8'h01);
    xfer(8'h23);
    expect_frame("data", {1'b1, 8'h79, 1'b0});
    chk("rd_addr", 16'h0123, rd_addr);
  endtask
  task automatic t_indexed_write_cmd();
    xfer(mscp_pkg::OP_INDEXED_WRITE_CMD);
    xfer(8'hC3);
    repeat (11 * BIT) @(posedge clk);
    chk("wr_addr", 16'h0124, wr_addr);
    chk("wr_data", 16'h00C3, {8'h00, wr_data});
  endtask
  // Run must not fire before the hold window has passed
  task automatic t_run();
    int n;
    n = 0;
    xfer(mscp_pkg::OP_RUN);
    while (run_pulse !== 1'b1 && n < 12 * BIT) begin
      @(posedge clk);
      n++;
    end
    chk("run", 16'h1, {15'h0, run_pulse});
    chk("hold", 16'h1, {15'h0, n > 9 * BIT});
  endtask
  // Supply entry must ignore the select pin and use the slow divider
  task automatic t_slow();
    int n;
    n = 0;
    entry_pin <= 1'b0;
    div_sel   <= 1'b0;
    do_reset(1'b0);
    while (line !== 1'b0 && n < 4 * mscp_pkg::DIV_SLOW) begin
      @(posedge clk);
      n++;
    end
    chk("slow gap", 16'h1, {15'h0, n > 3 * BIT && n <= 2 * mscp_pkg::DIV_SLOW});
  endtask
  initial begin
    @(posedge clk);
    t_por_hold();
    t_warm();
    t_read();
    t_indexed_write_cmd();
    t_run();
    t_slow();
    close_out();
  end
endmodule
